//--- src/flash_status_pkg.sv
// constants, field positions and carrier types of the flash status and pause block
package flash_status_pkg;

	// status byte field positions
	localparam int STATUS_BUSY_LO     = 0;
	localparam int STATUS_WEL         = 1;
	localparam int STATUS_ERASE_SUSP  = 2;
	localparam int STATUS_PROG_SUSP   = 3;
	localparam int STATUS_LOCKDOWN    = 4;
	localparam int STATUS_ID_LOCK     = 5;
	localparam int STATUS_RESERVED    = 6;
	localparam int STATUS_BUSY_HI     = 7;

	// configuration byte field positions
	localparam int CONFIG_PIN_FUNC    = 1;
	localparam int CONFIG_NO_PERM     = 3;
	localparam int CONFIG_GUARD_EN    = 7;

	// values after power-up and factory defaults
	localparam logic [7:0] STATUS_RESET    = 8'h00;
	localparam logic [7:0] CONFIG_RESET    = 8'h00;
	localparam logic       PIN_FUNC_RESET  = 1'h0;
	localparam logic       GUARD_FACTORY   = 1'h0;
	localparam logic       ID_LOCK_FACTORY = 1'h0;
	localparam logic       PERM_FACTORY    = 1'h0;

	// synchronised pin vector: index and idle level
	localparam int         PIN_CS          = 2;
	localparam int         PIN_SCLK        = 1;
	localparam int         PIN_PAUSE       = 0;
	localparam logic [2:0] PIN_IDLE        = 3'h5;

	// self-timed nonvolatile write of the guard enable bit
	localparam int CLK_PERIOD_PS      = 5000;
	localparam int NV_WRITE_TIME_NS   = 1000;
	localparam int NV_WRITE_CYCLES    = (NV_WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// pins from the host controller, all outside the clock domain
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic pause_n;
	} link_pins_t;

	// one-cycle command events from the command decoder
	typedef struct packed {
		logic       write_enable;
		logic       write_disable;
		logic       soft_reset;
		logic       program_start;
		logic       erase_start;
		logic       op_done;
		logic       suspend;
		logic       resume;
		logic       protect_write;
		logic       protect_lockdown;
		logic       identity_lockout;
		logic       status_write;
		logic       permanent_lock_set;
		logic [7:0] config_data;
	} flash_events_t;

	typedef enum logic [2:0] {
		P_RUN    = 3'h1,
		P_ARMED  = 3'h2,
		P_PAUSED = 3'h4
	} pause_state_t;

	typedef enum logic [4:0] {
		OP_IDLE       = 5'h01,
		OP_ERASE      = 5'h02,
		OP_PROGRAM    = 5'h04,
		OP_ERASE_SUSP = 5'h08,
		OP_PROG_SUSP  = 5'h10
	} op_state_t;

endpackage

//--- src/nv_flag_store.sv
// nonvolatile flag cells with self-timed write busy
`timescale 1ns/10ps
`default_nettype none
module nv_flag_store
	import flash_status_pkg::*;
#(
	parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic factory_init,
	input  wire logic guard_wr,
	input  wire logic guard_data,
	input  wire logic id_lock_set,
	input  wire logic perm_lock_set,
	output logic      guard_q,
	output logic      id_lock_q,
	output logic      perm_lock_q,
	output logic      write_busy
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic        next_guard;
	logic        next_id;
	logic        next_perm;

	// cells keep their value across sys_rst; only factory_init sets defaults
	always_comb begin
		next_guard = guard_q;
		next_id    = id_lock_q;
		next_perm  = perm_lock_q;
		next_count = count;
		if (factory_init) begin
			next_guard = GUARD_FACTORY;
			next_id    = ID_LOCK_FACTORY;
			next_perm  = PERM_FACTORY;
			next_count = 16'h0000;
		end else begin
			if (count != 16'h0000)
				next_count = count - 16'h0001;
			if (guard_wr && count == 16'h0000) begin
				next_guard = guard_data;
				next_count = 16'(WRITE_CYCLES);
			end
			if (id_lock_set)
				next_id = 1'b1;
			if (perm_lock_set)
				next_perm = 1'b1;
		end
		if (sys_rst)
			next_count = 16'h0000;
	end

	always_ff @(posedge clk) begin
		guard_q     <= next_guard;
		id_lock_q   <= next_id;
		perm_lock_q <= next_perm;
		count       <= next_count;
		write_busy  <= next_count != 16'h0000;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || factory_init);

	a_id_lock_sticky: assert property (id_lock_q |=> id_lock_q)
		else $error("identity lock cell cleared");
	a_perm_sticky: assert property (perm_lock_q |=> perm_lock_q)
		else $error("permanent lock cell cleared");
	a_guard_write: assert property (guard_wr && !write_busy && count == 16'h0000 |=> guard_q == $past(guard_data) && write_busy)
		else $error("guard enable write not taken");
endmodule
`default_nettype wire

//--- src/serial_flash_status_hold.sv
// status flags, configuration bits and pause logic of a serial flash
`timescale 1ns/10ps
`default_nettype none
module serial_flash_status_hold
	import flash_status_pkg::*;
#(
	parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
	input  wire logic                            clk,
	input  wire logic                            sys_rst,
	input  wire logic                            factory_init,
	input  wire flash_status_pkg::link_pins_t    pins,
	input  wire logic                            so_data,
	input  wire logic                            so_drive,
	input  wire logic                            quad_command_mode,
	input  wire flash_status_pkg::flash_events_t events,
	output logic                                 so_out,
	output logic                                 so_oe,
	output logic                                 sclk_rise,
	output logic                                 sclk_fall,
	output logic                                 serial_if_reset,
	output logic                                 paused,
	output logic                                 write_cmd_allowed,
	output logic [7:0]                           device_state_flags,
	output logic [7:0]                           io_and_protect_settings
);
	import flash_status_pkg::*;

	logic [2:0]   pin_meta;
	logic [2:0]   pin_sync;
	logic [2:0]   pin_prev;
	pause_state_t pause_state;
	pause_state_t next_pause_state;
	op_state_t    op_state;
	op_state_t    next_op_state;
	logic         write_enable_latch_flag;
	logic         next_wel;
	logic         protect_lockdown_flag;
	logic         next_lockdown;
	logic         pin_function_select;
	logic         next_pin_func;
	logic         next_so_out;
	logic         next_so_oe;
	logic         next_sclk_rise;
	logic         next_sclk_fall;
	logic         next_if_reset;
	logic [7:0]   next_flags;
	logic [7:0]   next_settings;
	logic         guard_pin_enable;
	logic         id_locked;
	logic         perm_locked;
	logic         nv_busy;
	logic         selected;
	logic         sclk_low;
	logic         pause_low;
	logic         pause_fall;
	logic         pause_allowed;
	logic         sclk_up;
	logic         sclk_down;
	logic         wel_clear;
	logic         op_busy;

	// two-flop synchronisers plus an edge history flop on the second stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_meta <= PIN_IDLE;
			pin_sync <= PIN_IDLE;
			pin_prev <= PIN_IDLE;
		end else begin
			pin_meta <= pins;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// decoded pin levels and edges
	always_comb begin
		selected      = !pin_sync[PIN_CS];
		sclk_low      = !pin_sync[PIN_SCLK];
		pause_low     = !pin_sync[PIN_PAUSE];
		pause_fall    = pin_prev[PIN_PAUSE] && !pin_sync[PIN_PAUSE];
		sclk_up       = !pin_prev[PIN_SCLK] && pin_sync[PIN_SCLK];
		sclk_down     = pin_prev[PIN_SCLK] && !pin_sync[PIN_SCLK];
		pause_allowed = !quad_command_mode && !pin_function_select;
	end

	// pause state machine and gated serial signals
	always_comb begin
		next_pause_state = pause_state;
		next_if_reset    = 1'b0;
		unique case (pause_state)
			P_RUN: begin
				if (selected && pause_allowed && pause_fall)
					next_pause_state = sclk_low ? P_PAUSED : P_ARMED;
			end
			P_ARMED: begin
				if (!selected || !pause_allowed || !pause_low)
					next_pause_state = P_RUN;
				else if (sclk_low)
					next_pause_state = P_PAUSED;
			end
			P_PAUSED: begin
				if (!selected) begin
					next_pause_state = P_RUN;
					next_if_reset    = 1'b1;
				end else if (!pause_allowed) begin
					next_pause_state = P_RUN;
				end else if (!pause_low && sclk_low) begin
					next_pause_state = P_RUN;
				end
			end
		endcase
		next_so_out    = so_data;
		next_so_oe     = selected && so_drive && next_pause_state != P_PAUSED;
		next_sclk_rise = selected && sclk_up && next_pause_state != P_PAUSED;
		next_sclk_fall = selected && sclk_down && next_pause_state != P_PAUSED;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pause_state     <= P_RUN;
			so_out          <= 1'b0;
			so_oe           <= 1'b0;
			sclk_rise       <= 1'b0;
			sclk_fall       <= 1'b0;
			serial_if_reset <= 1'b0;
			paused          <= 1'b0;
		end else begin
			pause_state     <= next_pause_state;
			so_out          <= next_so_out;
			so_oe           <= next_so_oe;
			sclk_rise       <= next_sclk_rise;
			sclk_fall       <= next_sclk_fall;
			serial_if_reset <= next_if_reset;
			paused          <= next_pause_state == P_PAUSED;
		end
	end

	// internal operation tracking, write enable latch and volatile flags
	always_comb begin
		next_op_state = op_state;
		next_lockdown = protect_lockdown_flag;
		next_pin_func = pin_function_select;
		unique case (op_state)
			OP_IDLE: begin
				if (events.erase_start && write_enable_latch_flag)
					next_op_state = OP_ERASE;
				else if (events.program_start && write_enable_latch_flag)
					next_op_state = OP_PROGRAM;
			end
			OP_ERASE: begin
				if (events.op_done)
					next_op_state = OP_IDLE;
				else if (events.suspend)
					next_op_state = OP_ERASE_SUSP;
			end
			OP_PROGRAM: begin
				if (events.op_done)
					next_op_state = OP_IDLE;
				else if (events.suspend)
					next_op_state = OP_PROG_SUSP;
			end
			OP_ERASE_SUSP: begin
				if (events.resume)
					next_op_state = OP_ERASE;
			end
			OP_PROG_SUSP: begin
				if (events.resume)
					next_op_state = OP_PROGRAM;
			end
		endcase
		if (events.soft_reset)
			next_op_state = OP_IDLE;
		op_busy   = op_state == OP_ERASE || op_state == OP_PROGRAM;
		wel_clear = events.write_disable || events.soft_reset || events.suspend
			|| (op_busy && events.op_done) || events.protect_write
			|| events.protect_lockdown || events.identity_lockout
			|| events.status_write;
		next_wel = write_enable_latch_flag;
		if (events.write_enable && !events.soft_reset)
			next_wel = 1'b1;
		else if (wel_clear)
			next_wel = 1'b0;
		if (events.protect_lockdown && write_enable_latch_flag)
			next_lockdown = 1'b1;
		if (events.status_write)
			next_pin_func = events.config_data[CONFIG_PIN_FUNC];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			op_state                <= OP_IDLE;
			write_enable_latch_flag <= 1'b0;
			protect_lockdown_flag   <= 1'b0;
			pin_function_select     <= PIN_FUNC_RESET;
			write_cmd_allowed       <= 1'b0;
		end else begin
			op_state                <= next_op_state;
			write_enable_latch_flag <= next_wel;
			protect_lockdown_flag   <= next_lockdown;
			pin_function_select     <= next_pin_func;
			write_cmd_allowed       <= next_wel;
		end
	end

	// nonvolatile cells; the guard write runs self-timed and shows as busy
	nv_flag_store #(
		.WRITE_CYCLES (NV_CYCLES)
	) u_nv (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.factory_init  (factory_init),
		.guard_wr      (events.status_write),
		.guard_data    (events.config_data[CONFIG_GUARD_EN]),
		.id_lock_set   (events.identity_lockout && write_enable_latch_flag),
		.perm_lock_set (events.permanent_lock_set && write_enable_latch_flag && !protect_lockdown_flag),
		.guard_q       (guard_pin_enable),
		.id_lock_q     (id_locked),
		.perm_lock_q   (perm_locked),
		.write_busy    (nv_busy)
	);

	// read-only views; nothing the host writes lands here directly
	always_comb begin
		next_flags                    = STATUS_RESET;
		// busy follows the state being entered, so suspend and resume show at once
		next_flags[STATUS_BUSY_LO]    = nv_busy
			|| next_op_state inside {OP_ERASE, OP_PROGRAM};
		next_flags[STATUS_BUSY_HI]    = next_flags[STATUS_BUSY_LO];
		next_flags[STATUS_WEL]        = next_wel;
		next_flags[STATUS_ERASE_SUSP] = next_op_state == OP_ERASE_SUSP;
		next_flags[STATUS_PROG_SUSP]  = next_op_state == OP_PROG_SUSP;
		next_flags[STATUS_LOCKDOWN]   = next_lockdown;
		next_flags[STATUS_ID_LOCK]    = id_locked;
		next_flags[STATUS_RESERVED]   = 1'b0;
		next_settings                  = CONFIG_RESET;
		next_settings[CONFIG_PIN_FUNC] = next_pin_func;
		next_settings[CONFIG_NO_PERM]  = !perm_locked;
		next_settings[CONFIG_GUARD_EN] = guard_pin_enable;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			device_state_flags      <= STATUS_RESET;
			io_and_protect_settings <= CONFIG_RESET;
		end else begin
			device_state_flags      <= next_flags;
			io_and_protect_settings <= next_settings;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_quad_no_pause: assert property (quad_command_mode |=> !paused)
		else $error("paused while in quad command mode");
	a_pause_powerup: assert property (disable iff (1'b0) sys_rst |=> !pin_function_select)
		else $error("pin function select not cleared at power-up");
	a_pause_entry: assert property (pause_state == P_RUN && selected && pause_allowed
		&& pause_fall && sclk_low |=> paused && !so_oe)
		else $error("pause not entered with clock low");
	a_pause_defer: assert property (pause_state == P_RUN && selected && pause_allowed
		&& pause_fall && !sclk_low |=> !paused ##0 pause_state == P_ARMED)
		else $error("pause entry not deferred");
	a_pause_exit: assert property (pause_state == P_PAUSED && selected && pause_allowed
		&& !pause_low && sclk_low |=> !paused)
		else $error("pause not left on rise with clock low");
	a_pause_quiet: assert property (paused |-> !so_oe && !sclk_rise && !sclk_fall)
		else $error("serial activity while paused");
	a_pause_holds: assert property (pause_state == P_PAUSED && selected && pause_allowed
		&& pause_low |=> paused [*1])
		else $error("pause dropped while input low");
	a_select_reset: assert property (pause_state == P_PAUSED && !selected
		|=> serial_if_reset && !paused ##1 !serial_if_reset)
		else $error("select rise in pause did not reset interface once");
	a_busy_pair: assert property (device_state_flags[STATUS_BUSY_LO]
		== device_state_flags[STATUS_BUSY_HI])
		else $error("busy bits disagree");
	a_busy_erase: assert property (op_state == OP_ERASE && !events.suspend
		&& !events.op_done && !events.soft_reset |=> device_state_flags[STATUS_BUSY_LO])
		else $error("busy bit missed during erase");
	a_wel_gates: assert property (op_state == OP_IDLE && !write_enable_latch_flag
		|=> op_state == OP_IDLE)
		else $error("operation started without write enable");
	a_wel_clears: assert property (events.write_disable && !events.write_enable
		|=> !device_state_flags[STATUS_WEL] && !write_cmd_allowed)
		else $error("write disable did not clear latch");
	a_erase_susp: assert property (op_state == OP_ERASE && events.suspend && !events.op_done
		&& !events.soft_reset && !events.write_enable && !nv_busy
		|=> device_state_flags[STATUS_ERASE_SUSP] && !device_state_flags[STATUS_BUSY_LO]
		##1 !write_enable_latch_flag || $past(events.write_enable))
		else $error("erase suspend not flagged");
	a_lockdown_sticks: assert property (device_state_flags[STATUS_LOCKDOWN]
		|=> device_state_flags[STATUS_LOCKDOWN])
		else $error("lock-down flag cleared without power cycle");
	a_reserved_zero: assert property (!device_state_flags[STATUS_RESERVED]
		&& (io_and_protect_settings & 8'h75) == 8'h00)
		else $error("reserved bit reads nonzero");
	a_perm_shows: assert property (perm_locked && !factory_init
		|=> !io_and_protect_settings[CONFIG_NO_PERM])
		else $error("permanent lock not shown");
endmodule
`default_nettype wire

//--- bench/spi_host_model.sv
// host controller model driving select, serial clock and pause pins
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	input  wire logic                         select,
	input  wire logic                         hold,
	input  wire logic                         clk_run,
	output var  flash_status_pkg::link_pins_t pins
);
	import flash_status_pkg::*;
	logic sclk_q;
	// serial clock toggles only within a frame, rests low between frames
	initial begin
		sclk_q = 1'b0;
		#3.7;
		forever begin
			#62.5;
			sclk_q = (select && clk_run) ? ~sclk_q : 1'b0;
		end
	end
	// select stays low through a pause; resume by raising pause with select low
	assign pins = '{cs_n: ~select, sclk: sclk_q, pause_n: ~hold};
endmodule
`default_nettype wire

//--- bench/serial_flash_status_hold_tb_top.sv
// self-checking bench of the flash status and pause block
`timescale 1ns/10ps
`default_nettype none
module serial_flash_status_hold_tb_top;
	import flash_status_pkg::*;
	localparam int NV = 4;
	localparam int EW = 0, WD = 1, SR = 2, PS = 3, ES = 4, OD = 5, SU = 6, RS = 7;
	localparam int PW = 8, PL = 9, IL = 10, SW = 11, PM = 12;
	logic          clk, sys_rst, factory_init, so_data, so_drive, quad;
	logic          sel, hold, run, s;
	logic          so_out, so_oe, sclk_rise, sclk_fall, if_rst, paused, allowed;
	logic [7:0]    flags, cfg;
	flash_events_t ev;
	link_pins_t    pins;
	int            failures, check_count, cycles, rises, r0, falls, f0, i;
	int            clr [3] = '{WD, SR, PW};

	spi_host_model host (.select(sel), .hold(hold), .clk_run(run), .pins(pins));
	serial_flash_status_hold #(.NV_CYCLES(NV)) dut (
		.clk(clk), .sys_rst(sys_rst), .factory_init(factory_init), .pins(pins),
		.so_data(so_data), .so_drive(so_drive), .quad_command_mode(quad),
		.events(ev), .so_out(so_out), .so_oe(so_oe), .sclk_rise(sclk_rise),
		.sclk_fall(sclk_fall), .serial_if_reset(if_rst), .paused(paused),
		.write_cmd_allowed(allowed), .device_state_flags(flags),
		.io_and_protect_settings(cfg)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// cycle ceiling and count of forwarded clock rises
	always @(posedge clk) begin
		cycles++;
		if (sclk_rise === 1'b1) rises++;
		if (sclk_fall === 1'b1) falls++;
		if (cycles == 40000) begin
			failures++;
			test_done();
		end
	end

	task automatic test_done();
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one-cycle command event, field k counted from the top of the struct
	task automatic fire(input int k, input logic [7:0] d);
		flash_events_t e;
		e = '0;
		e[20-k] = 1'b1;
		e.config_data = d;
		tick(1);
		ev = e;
		tick(1);
		ev = '0;
	endtask
	task automatic power_up(input logic fac);
		sys_rst = 1'b1;
		factory_init = fac;
		tick(16);
		sys_rst = 1'b0;
		factory_init = 1'b0;
		tick(3);
	endtask
	task automatic wait_pause(input logic want, input int lim);
		for (int j = 0; j < lim && paused !== want; j++) tick(1);
		chk("paused", {7'h00, want}, {7'h00, paused});
	endtask
	// pause request inside a frame that must be ignored
	task automatic no_pause();
		s = 1'b0;
		sel = 1'b1;
		tick(4);
		hold = 1'b1;
		repeat (20) begin
			tick(1);
			s = s | paused;
		end
		chk("ignored pause", 8'h00, {7'h00, s});
		hold = 1'b0;
		tick(4);
		sel = 1'b0;
		tick(4);
	endtask

	initial begin
		{so_data, quad, sel, hold, run} = '0;
		so_drive = 1'b1;
		ev = '0;
		{failures, check_count, cycles, rises, falls} = '0;
		power_up(1'b1);
		chk("flags", 8'h00, flags);
		chk("config", 8'h08, cfg);
		fire(ES, 8'h00);
		fire(PL, 8'h00);
		chk("flags", 8'h00, flags);
		// erase then program, each suspended, resumed and completed
		for (i = 0; i < 2; i++) begin
			fire(EW, 8'h00);
			chk("allowed", 8'h01, {7'h00, allowed});
			fire(i ? PS : ES, 8'h00);
			chk("flags", 8'h83, flags);
			fire(SU, 8'h00);
			chk("flags", i ? 8'h08 : 8'h04, flags);
			fire(RS, 8'h00);
			chk("flags", 8'h81, flags);
			fire(OD, 8'h00);
			chk("flags", 8'h00, flags);
		end
		for (i = 0; i < 3; i++) begin
			fire(EW, 8'h00);
			fire(clr[i], 8'h00);
			chk("flags", 8'h00, flags);
		end
		// configuration write with all ones: busy while the cell is written
		fire(EW, 8'h00);
		fire(SW, 8'hFF);
		tick(1);
		chk("flags", 8'h81, flags);
		tick(NV + 2);
		chk("flags", 8'h00, flags);
		chk("config", 8'h8A, cfg);
		no_pause();
		fire(SW, 8'h00);
		tick(NV + 2);
		chk("config", 8'h08, cfg);
		quad = 1'b1;
		no_pause();
		quad = 1'b0;
		// pause with the serial clock resting low
		sel = 1'b1;
		tick(4);
		hold = 1'b1;
		wait_pause(1'b1, 10);
		chk("so_oe", 8'h00, {7'h00, so_oe});
		tick(40);
		chk("paused", 8'h01, {7'h00, paused});
		hold = 1'b0;
		wait_pause(1'b0, 10);
		tick(2);
		chk("so_oe", 8'h01, {7'h00, so_oe});
		so_data = 1'b1;
		tick(2);
		chk("so_out", 8'h01, {7'h00, so_out});
		// pause edges while the serial clock is high are deferred
		run = 1'b1;
		@(posedge pins.sclk);
		tick(1);
		hold = 1'b1;
		tick(6);
		chk("paused", 8'h00, {7'h00, paused});
		wait_pause(1'b1, 20);
		r0 = rises;
		f0 = falls;
		tick(60);
		chk("rises", 8'h00, 8'(rises - r0));
		chk("falls", 8'h00, 8'(falls - f0));
		chk("paused", 8'h01, {7'h00, paused});
		@(posedge pins.sclk);
		tick(1);
		hold = 1'b0;
		tick(6);
		chk("paused", 8'h01, {7'h00, paused});
		wait_pause(1'b0, 20);
		tick(60);
		chk("rises seen", 8'h01, {7'h00, rises > r0});
		chk("falls seen", 8'h01, {7'h00, falls > f0});
		// select raised in mid-pause abandons the sequence
		hold = 1'b1;
		wait_pause(1'b1, 30);
		sel = 1'b0;
		s = 1'b0;
		repeat (8) begin
			tick(1);
			s = s | if_rst;
		end
		chk("if reset", 8'h01, {7'h00, s});
		chk("paused", 8'h00, {7'h00, paused});
		{hold, run} = '0;
		// lock-down, permanent lock and identity lockout across power cycles
		fire(EW, 8'h00);
		fire(PL, 8'h00);
		chk("flags", 8'h10, flags);
		fire(EW, 8'h00);
		fire(PM, 8'h00);
		tick(1);
		chk("config", 8'h08, cfg);
		power_up(1'b0);
		chk("flags", 8'h00, flags);
		fire(EW, 8'h00);
		fire(PM, 8'h00);
		tick(1);
		chk("config", 8'h00, cfg);
		fire(EW, 8'h00);
		fire(IL, 8'h00);
		tick(1);
		chk("flags", 8'h20, flags);
		power_up(1'b0);
		chk("flags", 8'h20, flags);
		chk("config", 8'h00, cfg);
		test_done();
	end
endmodule
`default_nettype wire
